// >>> src/hmi_defs.svh
// constants of the host micro interface
// included by the package, the serial engine and the top module
`ifndef HMI_DEFS_SVH
`define HMI_DEFS_SVH
`define HMI_AW 11
`define HMI_DW 8
`define HMI_NCH 8
`define HMI_NEV 8
`define HMI_NPIN 25
// pin vector reset: select, strobes, direction idle high
`define HMI_PIN_RST 25'h1c0_0000
`define HMI_A_ISTAT 11'h7f0
`define HMI_A_IMASK 11'h7f1
`define HMI_A_TEST 11'h7f2
`define HMI_SER_CW 5'h0c
`define HMI_SER_LEN 5'h14
`define HMI_SER_RW 11
`endif

// >>> src/hmi_pkg.sv
// types of the host micro interface
// assumes hmi_defs.svh on the include path
`include "hmi_defs.svh"
package hmi_pkg;
   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [`HMI_AW-1:0] addr;
      logic [`HMI_DW-1:0] wdata;
   } hmi_req_t;
   typedef enum logic [2:0]
   {
      PAR_IDLE = 3'h1,
      PAR_ACT = 3'h2,
      PAR_WAIT = 3'h4
   } hmi_par_st_t;
   typedef enum logic [2:0]
   {
      SER_IDLE = 3'h1,
      SER_SHIFT = 3'h2,
      SER_WAIT = 3'h4
   } hmi_ser_st_t;
endpackage

// >>> src/hmi_sync.sv
// two flip-flop synchroniser for a vector of pins
// assumes every bit is an independent level
`timescale 1ns/1ps
`default_nettype none
module hmi_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // pins and synchronised copy
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta_ff <= RST;
         q_ff <= RST;
      end
      else
      begin
         meta_ff <= i_d;
         q_ff <= meta_ff;
      end
   end
   assign o_q = q_ff;
endmodule
`default_nettype wire

// >>> src/hmi_serial.sv
// four-wire serial engine: rw flag, 11 address bits, 8 data bits
// assumes sclk edges as one-cycle pulses from the sampled pin
`timescale 1ns/1ps
`default_nettype none
`include "hmi_defs.svh"
module hmi_serial (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // sampled link
   input wire logic i_en,
   input wire logic i_sclk_rise,
   input wire logic i_sclk_fall,
   input wire logic i_sin,
   // read answer
   input wire logic [`HMI_DW-1:0] i_rdata,
   input wire logic i_rdata_vld,
   // request and serial output
   output hmi_pkg::hmi_req_t o_req,
   output logic o_sout,
   output logic o_sout_oe
);
   import hmi_pkg::*;
   hmi_ser_st_t st_ff, nxt_st;
   logic [4:0] cnt_ff, nxt_cnt;
   logic [19:0] sr_ff, nxt_sr;
   logic [`HMI_DW-1:0] out_ff, nxt_out;
   logic sout_ff, nxt_sout;
   hmi_req_t req_ff, nxt_req;
   logic rdf_ff, nxt_rdf;
   always_comb
   begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_sr = sr_ff;
      nxt_out = out_ff;
      nxt_sout = sout_ff;
      nxt_req = '0;
      nxt_rdf = rdf_ff;
      if (i_rdata_vld)
         nxt_out = i_rdata;
      case (st_ff)
         SER_IDLE:
         begin
            nxt_cnt = '0;
            nxt_rdf = 1'b0;
            if (i_en)
               nxt_st = SER_SHIFT;
         end
         SER_SHIFT:
         begin
            if (i_sclk_rise)
            begin
               nxt_sr = {sr_ff[18:0], i_sin};
               nxt_cnt = cnt_ff + 5'h1;
               if (nxt_cnt == `HMI_SER_CW && nxt_sr[`HMI_SER_RW])
               begin
                  nxt_req.rd = 1'b1;
                  nxt_rdf = 1'b1;
                  nxt_req.addr = nxt_sr[`HMI_AW-1:0];
               end
               if (nxt_cnt == `HMI_SER_LEN)
               begin
                  nxt_st = SER_WAIT;
                  nxt_req.wr = ~nxt_sr[19];
                  nxt_req.addr = nxt_sr[18:8];
                  nxt_req.wdata = nxt_sr[7:0];
               end
            end
            // output moves on the falling edge only
            if (i_sclk_fall && cnt_ff >= `HMI_SER_CW)
            begin
               nxt_sout = out_ff[`HMI_DW-1];
               nxt_out = {out_ff[`HMI_DW-2:0], 1'b0};
            end
         end
         SER_WAIT: nxt_st = SER_WAIT;
         default: nxt_st = SER_IDLE;
      endcase
      // a fresh select is needed for every frame
      if (!i_en)
         nxt_st = SER_IDLE;
   end
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st_ff <= SER_IDLE;
         cnt_ff <= '0;
         sr_ff <= '0;
         out_ff <= '0;
         sout_ff <= 1'b0;
         req_ff <= '0;
         rdf_ff <= 1'b0;
      end
      else
      begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         sr_ff <= nxt_sr;
         out_ff <= nxt_out;
         sout_ff <= nxt_sout;
         req_ff <= nxt_req;
         rdf_ff <= nxt_rdf;
      end
   end
   assign o_req = req_ff;
   assign o_sout = sout_ff;
   // read data driven only after the control word of a read
   // rw flag kept apart: the shift register moves on under it
   assign o_sout_oe = i_en && st_ff != SER_IDLE && rdf_ff;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_sout_fall:
      assert property (!i_sclk_fall |=> $stable(o_sout))
      else $error("serial out moved off a falling edge");
   a_ser_write:
      assert property (o_req.wr |-> $past(cnt_ff) == 5'h13)
      else $error("serial write before the full frame");
endmodule
`default_nettype wire

// >>> src/hmi_top.sv
// host micro interface: parallel bus in two styles or serial link
// assumes pins asynchronous to i_clk, line data and events on i_clk
`timescale 1ns/1ps
`default_nettype none
`include "hmi_defs.svh"
module hmi_top (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // host pins
   input wire logic i_sel_n,
   input wire logic [`HMI_AW-1:0] i_addr,
   input wire logic [`HMI_DW-1:0] i_data,
   output logic [`HMI_DW-1:0] o_data,
   output logic [`HMI_DW-1:0] o_data_oe,
   input wire logic i_bus_style_select,
   input wire logic i_rw_wr_sin,
   input wire logic i_strobe_sclk,
   input wire logic i_serial_host_enable,
   input wire logic i_line_driver_float,
   output logic o_int_o,
   output logic o_int_oe,
   // line transmit pairs from the channels
   input wire logic [2*`HMI_NCH-1:0] i_line_tx,
   output logic [2*`HMI_NCH-1:0] o_line_tx_pair_o,
   output logic [2*`HMI_NCH-1:0] o_line_tx_pair_oe,
   // internal register port
   output logic [`HMI_AW-1:0] o_reg_addr,
   output logic [`HMI_DW-1:0] o_reg_wdata,
   output logic o_reg_wr,
   output logic o_reg_rd,
   input wire logic [`HMI_DW-1:0] i_reg_rdata,
   // events and test mode
   input wire logic [`HMI_NEV-1:0] i_event,
   output logic o_test_mode
);
   import hmi_pkg::*;

   function automatic logic is_local(input logic [`HMI_AW-1:0] a);
      is_local = a == `HMI_A_ISTAT || a == `HMI_A_IMASK ||
         a == `HMI_A_TEST;
   endfunction

   // all pins pass two flip-flops first
   logic [`HMI_NPIN-1:0] pin_s;
   logic sel_n_s, strobe_s, dir_s, style_s, ser_mode_s, float_s;
   logic [`HMI_AW-1:0] addr_s;
   logic [`HMI_DW-1:0] data_s;
   hmi_sync #(
      .W(`HMI_NPIN),
      .RST(`HMI_PIN_RST)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_d({i_sel_n, i_strobe_sclk, i_rw_wr_sin, i_bus_style_select,
         i_serial_host_enable, i_line_driver_float, i_addr, i_data}),
      .o_q(pin_s)
   );
   assign {sel_n_s, strobe_s, dir_s, style_s, ser_mode_s, float_s,
      addr_s, data_s} = pin_s;

   // serial clock edges from the sampled pin
   logic sclk_d_ff, nxt_sclk_d;
   logic sclk_rise, sclk_fall;
   assign nxt_sclk_d = strobe_s;
   assign sclk_rise = strobe_s && !sclk_d_ff;
   assign sclk_fall = !strobe_s && sclk_d_ff;

   // parallel access decode
   logic par_act, par_rd;
   always_comb
   begin
      par_act = !sel_n_s && !ser_mode_s;
      if (style_s)
      begin
         par_act = par_act && (!strobe_s || !dir_s);
         par_rd = !strobe_s;
      end
      else
      begin
         par_act = par_act && !strobe_s;
         par_rd = dir_s;
      end
   end

   hmi_par_st_t st_ff, nxt_st;
   hmi_req_t par_req_ff, nxt_par_req;
   logic rd_ff, nxt_rd;
   logic [`HMI_AW-1:0] lat_a_ff, nxt_lat_a;
   logic [`HMI_DW-1:0] lat_d_ff, nxt_lat_d;
   always_comb
   begin
      nxt_st = st_ff;
      nxt_par_req = '0;
      nxt_rd = rd_ff;
      nxt_lat_a = lat_a_ff;
      nxt_lat_d = lat_d_ff;
      case (st_ff)
         PAR_IDLE:
            if (par_act)
            begin
               nxt_st = PAR_ACT;
               nxt_rd = par_rd;
               nxt_lat_a = addr_s;
               nxt_lat_d = data_s;
               nxt_par_req.rd = par_rd;
               nxt_par_req.addr = addr_s;
            end
         PAR_ACT:
            if (par_act)
            begin
               // write data taken as late as possible
               nxt_lat_a = addr_s;
               nxt_lat_d = data_s;
            end
            else
            begin
               nxt_st = PAR_WAIT;
               nxt_par_req.wr = !rd_ff;
               nxt_par_req.addr = lat_a_ff;
               nxt_par_req.wdata = lat_d_ff;
            end
         PAR_WAIT:
            if (sel_n_s)
               nxt_st = PAR_IDLE;
         default: nxt_st = PAR_IDLE;
      endcase
   end

   // serial engine
   hmi_req_t ser_req;
   logic sout, sout_oe;
   logic [`HMI_DW-1:0] rdata;
   logic rdv_ff, nxt_rdv;
   hmi_serial u_serial (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_en(ser_mode_s && !sel_n_s),
      .i_sclk_rise(sclk_rise),
      .i_sclk_fall(sclk_fall),
      .i_sin(dir_s),
      .i_rdata(rdata),
      .i_rdata_vld(rdv_ff && ser_mode_s),
      .o_req(ser_req),
      .o_sout(sout),
      .o_sout_oe(sout_oe)
   );

   hmi_req_t req;
   logic loc;
   assign req = ser_mode_s ? ser_req : par_req_ff;
   assign loc = is_local(req.addr);
   assign o_reg_addr = req.addr;
   assign o_reg_wdata = req.wdata;
   assign o_reg_wr = req.wr && !loc;
   assign o_reg_rd = req.rd && !loc;

   // local status, mask and test registers
   logic [`HMI_NEV-1:0] stat_ff, nxt_stat, mask_ff, nxt_mask;
   logic test_ff, nxt_test;
   logic loc_rd_ff, nxt_loc_rd;
   logic [`HMI_DW-1:0] loc_q_ff, nxt_loc_q, dout_ff, nxt_dout;
   always_comb
   begin
      nxt_stat = stat_ff;
      nxt_mask = mask_ff;
      nxt_test = test_ff;
      if (req.wr && req.addr == `HMI_A_ISTAT)
         nxt_stat = stat_ff & ~req.wdata;
      if (req.wr && req.addr == `HMI_A_IMASK)
         nxt_mask = req.wdata;
      if (req.wr && req.addr == `HMI_A_TEST)
         nxt_test = req.wdata[0];
      // a new event wins over a clear in the same cycle
      nxt_stat = nxt_stat | i_event;
      if (sel_n_s)
         nxt_test = 1'b0;
      nxt_rdv = req.rd;
      nxt_loc_rd = req.rd && loc;
      case (req.addr)
         `HMI_A_ISTAT: nxt_loc_q = stat_ff;
         `HMI_A_IMASK: nxt_loc_q = mask_ff;
         `HMI_A_TEST: nxt_loc_q = {{(`HMI_DW-1){1'b0}}, test_ff};
         default: nxt_loc_q = '0;
      endcase
      nxt_dout = dout_ff;
      if (rdv_ff && !ser_mode_s)
         nxt_dout = rdata;
   end
   assign rdata = loc_rd_ff ? loc_q_ff : i_reg_rdata;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sclk_d_ff <= 1'b1;
         st_ff <= PAR_IDLE;
         par_req_ff <= '0;
         rd_ff <= 1'b0;
         lat_a_ff <= '0;
         lat_d_ff <= '0;
         stat_ff <= '0;
         mask_ff <= '0;
         test_ff <= 1'b0;
         rdv_ff <= 1'b0;
         loc_rd_ff <= 1'b0;
         loc_q_ff <= '0;
         dout_ff <= '0;
      end
      else
      begin
         sclk_d_ff <= nxt_sclk_d;
         st_ff <= nxt_st;
         par_req_ff <= nxt_par_req;
         rd_ff <= nxt_rd;
         lat_a_ff <= nxt_lat_a;
         lat_d_ff <= nxt_lat_d;
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
         test_ff <= nxt_test;
         rdv_ff <= nxt_rdv;
         loc_rd_ff <= nxt_loc_rd;
         loc_q_ff <= nxt_loc_q;
         dout_ff <= nxt_dout;
      end
   end

   // pin drivers
   logic par_drive;
   assign par_drive = st_ff == PAR_ACT && rd_ff && par_act;
   assign o_data = ser_mode_s ? {{(`HMI_DW-1){1'b0}}, sout} : dout_ff;
   assign o_data_oe = ser_mode_s ? {{(`HMI_DW-1){1'b0}}, sout_oe}
      : {`HMI_DW{par_drive}};
   // open drain: level is always low, only the enable moves
   assign o_int_o = 1'b0;
   assign o_int_oe = |(stat_ff & mask_ff);
   assign o_line_tx_pair_o = i_line_tx;
   assign o_line_tx_pair_oe = {(2*`HMI_NCH){!float_s}};
   assign o_test_mode = test_ff;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_sel_idle;
      sel_n_s [*3];
   endsequence
   a_float_hiz:
      assert property (float_s |-> o_line_tx_pair_oe == '0)
      else $error("line pair driven while float requested");
   a_int_od:
      assert property (o_int_oe |-> o_int_o == 1'b0)
      else $error("interrupt pin driven high");
   a_int_hold:
      assert property ((stat_ff & mask_ff) != '0 |=>
         o_int_oe || $past(req.wr))
      else $error("interrupt released with unmasked status set");
   a_sel_ignore:
      assert property (s_sel_idle |-> !req.rd && !req.wr)
      else $error("access taken while deselected");
   a_test_clear:
      assert property (sel_n_s |=> !test_ff)
      else $error("test mode survives select high");
   a_rd_addr:
      assert property (par_req_ff.rd |-> par_req_ff.addr == $past(addr_s))
      else $error("parallel read used the wrong address");
   a_rd_data:
      assert property (rdv_ff && !ser_mode_s |=> dout_ff == $past(rdata))
      else $error("read data not presented");
   a_ser_mode:
      assert property (ser_mode_s [*2] |-> par_req_ff == '0)
      else $error("parallel access in serial mode");
   // write goes out one cycle after the strobe is seen released
   sequence s_par_release;
      st_ff == PAR_ACT && !par_act && !rd_ff;
   endsequence
   a_par_write:
      assert property (s_par_release |=> par_req_ff.wr &&
         par_req_ff.wdata == $past(lat_d_ff) &&
         par_req_ff.addr == $past(lat_a_ff))
      else $error("parallel write not issued at strobe release");
   a_ser_pins:
      assert property (ser_mode_s |-> o_data_oe[`HMI_DW-1:1] == '0)
      else $error("serial mode drove the upper data pins");
endmodule
`default_nettype wire

// >>> verification/hmi_host_model.sv
// host processor model: drives select, address, strobes and serial link
// assumes the bench resolves the data wire and feeds it back on i_dq
`timescale 1ns/1ps
`default_nettype none
module hmi_host_model (
   // clock
   input wire logic i_clk,
   // resolved data wire
   input wire logic [7:0] i_dq,
   // host pins
   output logic o_sel_n,
   output logic [10:0] o_addr,
   output logic [7:0] o_dq,
   output logic o_dq_oe,
   output logic o_style,
   output logic o_rw,
   output logic o_stb,
   output logic o_ser_en
);
   initial
   begin
      o_sel_n = 1'b1;
      o_addr = '0;
      o_dq = '0;
      o_dq_oe = 1'b0;
      o_style = 1'b0;
      o_rw = 1'b1;
      o_stb = 1'b1;
      o_ser_en = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // sel_en 0 keeps select high so the device must ignore the access
   task automatic par(input logic sty, wr, sel_en, input logic [10:0] a,
      input logic [7:0] d, output logic [7:0] q);
      o_ser_en <= 1'b0;
      o_style <= sty;
      wt(6);
      o_sel_n <= !sel_en;
      wt(6);
      o_addr <= a;
      o_dq <= d;
      o_dq_oe <= wr;
      o_rw <= !wr;
      o_stb <= sty & wr;
      wt(8);
      q = i_dq;
      o_stb <= 1'b1;
      o_rw <= 1'b1;
      wt(6);
      o_dq_oe <= 1'b0;
      o_sel_n <= 1'b1;
      wt(6);
   endtask
   // frame: rw flag, address msb first, data msb first
   task automatic ser(input logic wr, input logic [10:0] a,
      input logic [7:0] d, output logic [7:0] q);
      logic [19:0] f;
      f = {!wr, a, d};
      o_ser_en <= 1'b1;
      o_addr <= '0;
      wt(6);
      o_sel_n <= 1'b0;
      wt(6);
      for (int i = 19; i >= 0; i--)
      begin
         o_stb <= 1'b0;
         o_rw <= f[i];
         wt(4);
         if (i < 8)
            q[i] = i_dq[0];
         o_stb <= 1'b1;
         wt(4);
      end
      o_stb <= 1'b0;
      wt(4);
      o_sel_n <= 1'b1;
      wt(6);
      o_stb <= 1'b1;
      o_rw <= 1'b1;
   endtask
endmodule
`default_nettype wire

// >>> verification/test_host_micro_interface.sv
// bench for the host micro interface with a register file model
// assumes hmi_pkg and hmi_defs.svh compiled first
`timescale 1ns/1ps
`default_nettype none
module test_host_micro_interface;
   logic clk, rst_n, flt;
   logic [15:0] tx;
   logic [7:0] ev, dq, h_dq, o_data, o_data_oe;
   logic [7:0] reg_rdata = 8'h00, dq_last = 8'h00;
   logic [7:0] mem [0:2047];
   logic [10:0] h_addr, reg_addr;
   logic [7:0] reg_wdata;
   logic [15:0] pair_o, pair_oe;
   logic h_sel_n, h_oe, h_sty, h_rw, h_stb, h_ser;
   logic int_o, int_oe, reg_wr, reg_rd, tm;
   logic tm_seen = 1'b0;
   logic [18:0] wq[$];
   int failures, num_checks, nrd;
   hmi_top hmi_top_inst (.i_clk(clk), .i_rst_n(rst_n), .i_sel_n(h_sel_n),
      .i_addr(h_addr), .i_data(dq), .o_data(o_data),
      .o_data_oe(o_data_oe), .i_bus_style_select(h_sty),
      .i_rw_wr_sin(h_rw), .i_strobe_sclk(h_stb),
      .i_serial_host_enable(h_ser), .i_line_driver_float(flt),
      .o_int_o(int_o), .o_int_oe(int_oe), .i_line_tx(tx),
      .o_line_tx_pair_o(pair_o), .o_line_tx_pair_oe(pair_oe),
      .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .o_reg_wr(reg_wr),
      .o_reg_rd(reg_rd), .i_reg_rdata(reg_rdata), .i_event(ev),
      .o_test_mode(tm));
   hmi_host_model hmi_host_model_inst (.i_clk(clk), .i_dq(dq),
      .o_sel_n(h_sel_n), .o_addr(h_addr), .o_dq(h_dq), .o_dq_oe(h_oe),
      .o_style(h_sty), .o_rw(h_rw), .o_stb(h_stb), .o_ser_en(h_ser));
   // released wire shows the inverse of its last level, not a held value
   always_comb
      for (int i = 0; i < 8; i++)
         dq[i] = o_data_oe[i] ? o_data[i] : h_oe ? h_dq[i] : !dq_last[i];
   task automatic chk(input string n, input logic [18:0] e, g);
      num_checks++;
      if (e !== g)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // register file beside the internal port; expected writes come in order
   always @(posedge clk)
   begin
      logic [18:0] e;
      e = 'x;
      dq_last <= dq;
      if (tm)
         tm_seen <= 1'b1;
      if (reg_rd)
      begin
         nrd++;
         reg_rdata <= mem[reg_addr];
      end
      if (reg_wr)
      begin
         if (wq.size() > 0)
            e = wq.pop_front();
         chk("wr", e, {reg_addr, reg_wdata});
         mem[e[18:8]] = e[7:0];
      end
   end
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      repeat (40000) @(posedge clk);
      failures++;
      tally_and_finish();
   end
   task automatic lw(input logic [10:0] a, input logic [7:0] d);
      logic [7:0] q;
      hmi_host_model_inst.par(1'b0, 1'b1, 1'b1, a, d, q);
   endtask
   task automatic lr(input logic [10:0] a, output logic [7:0] q);
      hmi_host_model_inst.par(1'b1, 1'b0, 1'b1, a, 8'h00, q);
   endtask
   task automatic pulse(input logic [7:0] v);
      ev <= v;
      @(posedge clk);
      ev <= 8'h00;
      repeat (3) @(posedge clk);
   endtask
   initial
   begin
      logic [10:0] a;
      logic [7:0] d, q;
      int m;
      void'($urandom(77));
      rst_n = 1'b0;
      flt = 1'b0;
      ev = 8'h00;
      tx = 16'($urandom);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      chk("pair_oe", 16'hffff, pair_oe);
      chk("pair_o", tx, pair_o);
      chk("int_oe", 1'b0, int_oe);
      flt <= 1'b1;
      repeat (5) @(posedge clk);
      chk("pair_oe", 16'h0000, pair_oe);
      flt <= 1'b0;
      // write in one mode, read back in the next: style 0, 1, serial
      for (int k = 0; k < 6; k++)
      begin
         a = 11'($urandom_range(11'h7ef));
         d = 8'($urandom);
         wq.push_back({a, d});
         for (int j = 0; j < 2; j++)
         begin
            m = (k + j) % 3;
            if (m == 2)
               hmi_host_model_inst.ser(!j[0], a, d, q);
            else
               hmi_host_model_inst.par(m[0], !j[0], 1'b1, a, d, q);
         end
         chk("rd", d, q);
      end
      chk("nrd", 6, nrd);
      hmi_host_model_inst.par(1'b0, 1'b0, 1'b0, a, 8'h00, q);
      hmi_host_model_inst.par(1'b1, 1'b1, 1'b0, a, d, q);
      chk("nrd", 6, nrd);
      chk("wq", 0, wq.size());
      lw(11'h7f1, 8'h01);
      pulse(8'h06);
      chk("int_oe", 1'b0, int_oe);
      pulse(8'h01);
      chk("int_oe", 1'b1, int_oe);
      chk("int_o", 1'b0, int_o);
      lw(11'h7f0, 8'h01);
      chk("int_oe", 1'b0, int_oe);
      lr(11'h7f0, q);
      chk("stat", 8'h06, q);
      lw(11'h7f1, 8'hff);
      chk("int_oe", 1'b1, int_oe);
      lw(11'h7f0, 8'h06);
      chk("int_oe", 1'b0, int_oe);
      lw(11'h7f2, 8'h01);
      chk("tm_seen", 1'b1, tm_seen);
      chk("tm", 1'b0, tm);
      lr(11'h7f2, q);
      chk("tm_rd", 1'b0, q[0]);
      tally_and_finish();
   end
endmodule
`default_nettype wire
